// ---- verif/clock_pulse_generator_tb_top.sv ----
`timescale 1ns/1ps
`include "cpg_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module clock_pulse_generator_tb_top;
    import cpg_pkg::*;
    localparam int STAB = 8;
    logic        clk = 0, reset = 1, use_crystal = 0, refresh_req = 0;
    logic [2:0]  mode_req = 0, mode_select_pins;
    logic        oscillator_select, self_refresh, reg_select = 0, reg_write = 0, reg_word = 0;
    logic [31:0] reg_addr = 0, seed = 32'hf86a15e1;
    logic [15:0] reg_wdata = 0, reg_rdata, q, d;
    logic        sleep_req = 0, standby_req = 0, wake_req = 0, ak, reg_ack_w;
    logic [7:0]  module_stop = 0, module_tick;
    logic        core_tick, bus_tick, periph_tick, clock_output_pin, clock_out_enable_pin;
    logic        crystal_enable, settling;
    int          fails = 0, check_count = 0, c, b, p, t, m0, m1, n;
    int          divs[8] = '{1, 2, 3, 4, 6, 8, 8, 8};
    // Peripheral codes sit one step slower than core and bus codes
    int          pdivs[8] = '{2, 3, 4, 6, 8, 8, 8, 8};
    // Only the listed ratio codes are ever written
    logic [8:0]  legal[15] = '{9'h008, 9'h00a, 9'h00c, 9'h011, 9'h013, 9'h01a, 9'h01c,
                               9'h023, 9'h02c, 9'h05a, 9'h05c, 9'h063, 9'h06c, 9'h0a3, 9'h0ec};
    always #2.5 clk = ~clk;
    cpg_board_model u_cpg_board_model (.clk(clk), .mode_req(mode_req), .use_crystal(use_crystal),
        .refresh_req(refresh_req), .mode_select_pins(mode_select_pins),
        .oscillator_select(oscillator_select), .self_refresh(self_refresh));
    cpg_clock_gen #(.STAB_CYCLES(STAB), .MODULES(8)) u_cpg_clock_gen (.clk(clk), .reset(reset),
        .mode_select_pins(mode_select_pins), .oscillator_select(oscillator_select),
        .reg_select(reg_select), .reg_write(reg_write), .reg_word(reg_word),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sleep_req(sleep_req),
        .standby_req(standby_req), .wake_req(wake_req), .self_refresh(self_refresh),
        .module_stop(module_stop), .reg_rdata(reg_rdata), .reg_ack(reg_ack_w),
        .core_tick(core_tick), .bus_tick(bus_tick), .periph_tick(periph_tick),
        .module_tick(module_tick), .clock_output_pin(clock_output_pin),
        .clock_out_enable_pin(clock_out_enable_pin), .crystal_enable(crystal_enable),
        .settling(settling));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [15:0] mode_value(input int m);
        return m < 1 ? 16'h0e1a : m < 2 ? 16'h0e23 : m < 4 ? 16'h0e13 : 16'h0e0a;
    endfunction : mode_value
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // Request held across exactly one taking edge; ack is registered on that same edge and read at the next falling edge
    task automatic acc(input logic [31:0] a, input logic w, input logic wd, input logic [15:0] v);
        @(negedge clk);
        {reg_select, reg_write, reg_word, reg_addr, reg_wdata} = {1'b1, w, wd, a, v};
        @(negedge clk);
        ak = reg_ack_w;
        q = reg_rdata;
        reg_select = 0;
    endtask : acc
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        acc(a, 0, 1, 16'h0);
        `CHK("read ack", 1'b1, ak)
        `CHK("read data", e, q)
    endtask : rd
    task automatic do_reset(input int m);
        mode_req = 3'(m);
        reset = 1;
        repeat (5) @(negedge clk);
        `CHK("cke in reset", 1'b1, clock_out_enable_pin)
        reset = 0;
        repeat (2) @(negedge clk);
    endtask : do_reset
    task automatic wait_settle;
        n = 0;
        while (settling !== 1'b0) begin
            n++;
            if (n > STAB + 20) begin
                fails++;
                conclude();
            end
            @(negedge clk);
        end
    endtask : wait_settle
    // Window of 48 cycles is a whole number of periods for every divisor
    task automatic count;
        logic last;
        {c, b, p, t, m0, m1} = '0;
        repeat (4) @(negedge clk);
        last = clock_output_pin;
        repeat (48) begin
            @(negedge clk);
            c += core_tick;
            b += bus_tick;
            p += periph_tick;
            t += int'(clock_output_pin !== last);
            last = clock_output_pin;
            m0 += module_tick[0];
            m1 += module_tick[1];
        end
    endtask : count
    initial begin
        for (int m = 0; m < 6; m++) begin
            do_reset(m);
            rd(`CPG_ADDR_P4, mode_value(m));
            rd(`CPG_ADDR_AREA7, mode_value(m));
        end
        acc(`CPG_ADDR_P4, 0, 0, 16'h0);
        `CHK("byte access ack", 1'b0, ak)
        acc(32'hffc00004, 0, 1, 16'h0);
        `CHK("unmapped ack", 1'b0, ak)
        $display("test reset and decode done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            d = {seed[15:12], i[0], 2'b11, legal[seed[19:16] % 15]};
            module_stop = {7'h0, i[0]};
            acc(`CPG_ADDR_P4, 1, 1, d);
            `CHK("write ack", 1'b1, ak)
            wait_settle();
            rd(`CPG_ADDR_AREA7, d & 16'hefff);
            count();
            `CHK("core ticks", 48 / divs[d[8:6]], c)
            `CHK("bus ticks", 48 / divs[d[5:3]], b)
            `CHK("periph ticks", 48 / pdivs[d[2:0]], p)
            `CHK("pin toggles", i[0] ? 48 / divs[d[5:3]] : 0, t)
            `CHK("stopped module", i[0] ? 0 : 48 / pdivs[d[2:0]], m0)
            `CHK("running module", 48 / pdivs[d[2:0]], m1)
        end
        acc(`CPG_ADDR_P4, 1, 1, 16'h0823);
        wait_settle();
        `CHK("settle length", STAB, n)
        $display("test ratios done");
        count();
        `CHK("core ticks plls off", 24 / divs[0], c)
        `CHK("bus ticks plls off", 24 / divs[4], b)
        `CHK("periph ticks plls off", 24 / pdivs[3], p)
        acc(`CPG_ADDR_P4, 1, 1, 16'h0e23);
        wait_settle();
        `CHK("settle length again", STAB, n)
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            {sleep_req, standby_req} = k ? 2'b01 : 2'b10;
            @(negedge clk);
            {sleep_req, standby_req} = 2'b00;
            count();
            `CHK("ticks while stopped", 0, c + b + p)
            `CHK("cke while stopped", 1'b0, clock_out_enable_pin)
            wake_req = 1;
            @(negedge clk);
            wake_req = 0;
            wait_settle();
            `CHK("wake settle length", STAB, n)
            count();
            `CHK("core ticks after wake", 48 / divs[0], c)
        end
        $display("test power down done");
        refresh_req = 1;
        repeat (4) @(negedge clk);
        `CHK("cke in self refresh", 1'b0, clock_out_enable_pin)
        refresh_req = 0;
        use_crystal = 1;
        repeat (6) @(negedge clk);
        `CHK("cke after refresh", 1'b1, clock_out_enable_pin)
        `CHK("crystal enable", 1'b1, crystal_enable)
        use_crystal = 0;
        repeat (6) @(negedge clk);
        `CHK("crystal disable", 1'b0, crystal_enable)
        do_reset(4);
        rd(`CPG_ADDR_P4, 16'h0e0a);
        $display("test pins and second reset done");
        conclude();
    end
endmodule : clock_pulse_generator_tb_top

// ---- verif/cpg_board_model.sv ----
`timescale 1ns/1ps
module cpg_board_model (
    input  wire logic       clk,
    input  wire logic [2:0] mode_req,
    input  wire logic       use_crystal,
    input  wire logic       refresh_req,
    output logic [2:0]      mode_select_pins,
    output logic            oscillator_select,
    output logic            self_refresh
);
    initial begin
        mode_select_pins  = 3'h0;
        oscillator_select = 1'b0;
        self_refresh      = 1'b0;
    end
    // Board straps move on the falling edge only, well clear of the sampling edge
    always @(negedge clk) begin
        mode_select_pins  <= mode_req;
        oscillator_select <= use_crystal;
        self_refresh      <= refresh_req;
    end
endmodule : cpg_board_model

// ---- verilog/cpg_clock_gen.sv ----
`timescale 1ns/1ps
`include "cpg_consts.svh"
// Notes on behaviour
// - Three enables, core, bus and peripheral, each divided per register field.
// - Mode pins pick one of six modes with fixed ratios after power-on.
// - First PLL multiplies input by six; enable edges align to the base rate.
// - PLL enable bits start or stop the multiplied clock to save power.
// - Bus-phase output pin toggles in step with the bus enable.
// - Without the first PLL, input rate is halved for even duty.
// - Oscillator select pin chooses external clock or crystal oscillator.
// - Clock-out-enable pin low while unstable or self-refresh, high during reset.
// - Clock output pin toggles or is held low per register enable bit.
// - Sixteen-bit read/write register at two addresses, reset from mode pins.
// - Software writes change the three ratios independently.
// - Sleep and standby stop clocks; module standby gates single modules.
// - Stabilization count runs before resuming after standby or frequency change.
// - Mode 0 resets to 0e1a, mode 1 to 0e23.
// - Only listed low nine-bit ratio codes are legal.
// - Only power-on reset initializes register; word accesses only.
// - Bits 11,10,9 enables; core 8:6, bus 5:3, peripheral 2:0.
module cpg_clock_gen
    import cpg_pkg::*;
#(
    parameter int STAB_CYCLES = `CPG_STAB_CYCLES,
    parameter int MODULES     = 8
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic [2:0]         mode_select_pins,
    input  wire logic               oscillator_select,
    input  wire logic               reg_select,
    input  wire logic               reg_write,
    input  wire logic               reg_word,
    input  wire logic [31:0]        reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               sleep_req,
    input  wire logic               standby_req,
    input  wire logic               wake_req,
    input  wire logic               self_refresh,
    input  wire logic [MODULES-1:0] module_stop,
    output logic [15:0]             reg_rdata,
    output logic                    reg_ack,
    output logic                    core_tick,
    output logic                    bus_tick,
    output logic                    periph_tick,
    output logic [MODULES-1:0]      module_tick,
    output logic                    clock_output_pin,
    output logic                    clock_out_enable_pin,
    output logic                    crystal_enable,
    output logic                    settling
);
    logic [2:0]       mode_meta;
    logic [2:0]       mode_sync;
    logic [1:0]       osc_sync;
    logic             por_seen;
    logic [15:0]      frequency_control;
    logic [15:0]      next_frequency_control;
    logic [15:0]      next_rdata;
    logic             next_ack;
    logic             hit;
    cpg_state_e       state;
    cpg_state_e       next_state;
    logic [15:0]      stab_count;
    logic [15:0]      next_stab_count;
    logic             half_phase;
    logic             next_half_phase;
    cpg_ratio_t       per_code;
    logic             run;
    logic             core_raw;
    logic             bus_raw;
    logic             per_raw;
    logic             next_clock_out;
    logic             next_cke;
    logic [4:0]       core_div;
    logic [4:0]       bus_div;
    logic [4:0]       per_div;

    // Mode and oscillator select pins come from off-chip and pass two flops first
    always_ff @(posedge clk) begin
        mode_meta <= mode_select_pins;
        mode_sync <= mode_meta;
        osc_sync  <= {osc_sync[0], oscillator_select};
    end

    function automatic logic [15:0] mode_reset(input logic [2:0] m);
        case (m)
            3'h0:    mode_reset = `CPG_RESET_MODE0;
            3'h1:    mode_reset = `CPG_RESET_MODE1;
            3'h2,
            3'h3:    mode_reset = `CPG_RESET_MODE23;
            default: mode_reset = `CPG_RESET_MODE45;
        endcase
    endfunction : mode_reset

    // Ratio code to divisor in base cycles; unknown codes fall back to slowest
    function automatic logic [4:0] ratio_div(input cpg_ratio_t r);
        case (r)
            3'h0:    ratio_div = 5'h01;
            3'h1:    ratio_div = 5'h02;
            3'h2:    ratio_div = 5'h03;
            3'h3:    ratio_div = 5'h04;
            3'h4:    ratio_div = 5'h06;
            3'h5:    ratio_div = 5'h08;
            default: ratio_div = 5'h08;
        endcase
    endfunction : ratio_div

    assign hit = reg_select && reg_word && ((reg_addr == `CPG_ADDR_P4)
               || (reg_addr == `CPG_ADDR_AREA7));

    always_comb begin
        next_frequency_control = frequency_control;
        next_rdata             = reg_rdata;
        next_ack               = 1'b0;
        if (!por_seen) begin
            next_frequency_control = mode_reset(mode_sync);
        end else if (hit) begin
            next_ack = 1'b1;
            if (reg_write) begin
                next_frequency_control = reg_wdata & `CPG_WRITE_MASK;
            end else begin
                next_rdata = frequency_control;
            end
        end
    end

    // Mode pins settle through the synchroniser before being sampled
    always_ff @(posedge clk) begin
        if (reset) begin
            frequency_control <= `CPG_RESET_MODE0;
            reg_rdata         <= 16'h0000;
            reg_ack           <= 1'b0;
            por_seen          <= 1'b0;
        end else begin
            frequency_control <= next_frequency_control;
            reg_rdata         <= next_rdata;
            reg_ack           <= next_ack;
            por_seen          <= 1'b1;
        end
    end

    assign core_div = ratio_div(frequency_control[`CPG_CORE_MSB:`CPG_CORE_LSB]);
    assign bus_div  = ratio_div(frequency_control[`CPG_BUS_MSB:`CPG_BUS_LSB]);
    assign per_code = frequency_control[`CPG_PER_MSB:`CPG_PER_LSB];
    // Peripheral codes run one step slower than core and bus codes; 5 and up are unlisted
    assign per_div  = (per_code >= 3'h5) ? 5'h08 : ratio_div(3'(per_code + 3'h1));

    always_comb begin
        next_state      = state;
        next_stab_count = stab_count;
        next_half_phase = !half_phase;
        case (state)
            CPG_RUN: begin
                if (sleep_req || standby_req) begin
                    next_state = CPG_STOPPED;
                end else if (hit && reg_write && (reg_wdata[8:0] != frequency_control[8:0]
                             || reg_wdata[10:9] != frequency_control[10:9])) begin
                    next_state      = CPG_SETTLE;
                    next_stab_count = 16'(STAB_CYCLES);
                end
            end
            CPG_STOPPED: begin
                if (wake_req) begin
                    next_state      = CPG_SETTLE;
                    next_stab_count = 16'(STAB_CYCLES);
                end
            end
            CPG_SETTLE: begin
                if (stab_count <= 16'h0001) begin
                    next_state      = CPG_RUN;
                    next_stab_count = 16'h0000;
                end else begin
                    next_stab_count = stab_count - 16'h0001;
                end
            end
            default: next_state = CPG_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= CPG_SETTLE;
            stab_count <= 16'(STAB_CYCLES);
            half_phase <= 1'b0;
        end else begin
            state      <= next_state;
            stab_count <= next_stab_count;
            half_phase <= next_half_phase;
        end
    end

    // Bypassing the first PLL runs the dividers on alternate cycles, halving the rate
    // Second PLL only aligns phase, so its enable does not change the rate
    assign run = (state == CPG_RUN)
               && (frequency_control[`CPG_BIT_PLL1_EN] || half_phase);

    cpg_divider u_core (.clk(clk), .reset(reset), .run(run), .divisor(core_div),
                        .tick(core_raw));
    cpg_divider u_bus  (.clk(clk), .reset(reset), .run(run), .divisor(bus_div),
                        .tick(bus_raw));
    cpg_divider u_per  (.clk(clk), .reset(reset), .run(run), .divisor(per_div),
                        .tick(per_raw));

    always_comb begin
        next_clock_out = clock_output_pin;
        if (!frequency_control[`CPG_BIT_CLKOUT_EN]) begin
            next_clock_out = 1'b0;
        end else if (bus_raw) begin
            next_clock_out = ~clock_output_pin;
        end
        next_cke = !self_refresh && (state == CPG_RUN);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            core_tick            <= 1'b0;
            bus_tick             <= 1'b0;
            periph_tick          <= 1'b0;
            clock_output_pin     <= 1'b0;
            clock_out_enable_pin <= 1'b1;
            crystal_enable       <= 1'b0;
            settling             <= 1'b1;
        end else begin
            core_tick            <= core_raw;
            bus_tick             <= bus_raw;
            periph_tick          <= per_raw;
            clock_output_pin     <= next_clock_out;
            clock_out_enable_pin <= next_cke;
            crystal_enable       <= osc_sync[1];
            settling             <= (next_state == CPG_SETTLE);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < MODULES; gi++) begin : g_mod
            always_ff @(posedge clk) begin
                if (reset) begin
                    module_tick[gi] <= 1'b0;
                end else begin
                    module_tick[gi] <= per_raw && !module_stop[gi];
                end
            end
        end
    endgenerate

    property p_cke_low_in_refresh;
        @(posedge clk) disable iff (reset) self_refresh |=> !clock_out_enable_pin;
    endproperty
    a_cke_low_in_refresh: assert property (p_cke_low_in_refresh)
        else $error("clock out enable high during self refresh");

    property p_no_tick_stopped;
        @(posedge clk) disable iff (reset)
            state == CPG_STOPPED ##1 state == CPG_STOPPED |=> !core_tick;
    endproperty
    a_no_tick_stopped: assert property (p_no_tick_stopped)
        else $error("core tick while stopped");

    property p_wake_settles;
        @(posedge clk) disable iff (reset)
            (state == CPG_STOPPED && wake_req) |=> state == CPG_SETTLE;
    endproperty
    a_wake_settles: assert property (p_wake_settles)
        else $error("wake did not enter settling");

    property p_settle_ends;
        @(posedge clk) disable iff (reset)
            $rose(state == CPG_SETTLE) |-> ##[1:1000] state != CPG_SETTLE;
    endproperty
    a_settle_ends: assert property (p_settle_ends)
        else $error("settling never ended");

    property p_clkout_held;
        @(posedge clk) disable iff (reset)
            !frequency_control[`CPG_BIT_CLKOUT_EN] |=> !clock_output_pin;
    endproperty
    a_clkout_held: assert property (p_clkout_held)
        else $error("clock output toggled while disabled");

    property p_pll_off_no_tick;
        @(posedge clk) disable iff (reset)
            (!frequency_control[`CPG_BIT_PLL1_EN] && !half_phase) |=> !bus_raw;
    endproperty
    a_pll_off_no_tick: assert property (p_pll_off_no_tick)
        else $error("bus tick off the half-rate phase");

    property p_write_lands;
        @(posedge clk) disable iff (reset)
            (por_seen && hit && reg_write) |=>
                frequency_control == ($past(reg_wdata) & `CPG_WRITE_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("register write lost");

    property p_read_returns;
        @(posedge clk) disable iff (reset)
            (por_seen && hit && !reg_write) |=>
                reg_ack && reg_rdata == $past(frequency_control);
    endproperty
    a_read_returns: assert property (p_read_returns)
        else $error("register read wrong");

    c_sleep: cover property (@(posedge clk) disable iff (reset) state == CPG_STOPPED);
    c_settle: cover property (@(posedge clk) disable iff (reset)
        state == CPG_SETTLE ##1 state == CPG_RUN);
    c_write: cover property (@(posedge clk) disable iff (reset) hit && reg_write);
endmodule : cpg_clock_gen

// ---- verilog/cpg_consts.svh ----
`ifndef CPG_CONSTS_SVH
`define CPG_CONSTS_SVH

`define CPG_ADDR_P4           32'hffc00000
`define CPG_ADDR_AREA7        32'h1fc00000
`define CPG_FRQ_WIDTH         16
`define CPG_BIT_CLKOUT_EN     11
`define CPG_BIT_PLL1_EN       10
`define CPG_BIT_PLL2_EN       9
`define CPG_CORE_MSB          8
`define CPG_CORE_LSB          6
`define CPG_BUS_MSB           5
`define CPG_BUS_LSB           3
`define CPG_PER_MSB           2
`define CPG_PER_LSB           0
`define CPG_RESET_MODE0       16'h0e1a
`define CPG_RESET_MODE1       16'h0e23
`define CPG_RESET_MODE23      16'h0e13
`define CPG_RESET_MODE45      16'h0e0a
`define CPG_WRITE_MASK        16'hefff
`define CPG_STAB_TIME_NS      1000
`define CPG_CLK_PERIOD_NS     5
`define CPG_STAB_CYCLES       ((`CPG_STAB_TIME_NS + `CPG_CLK_PERIOD_NS - 1) / `CPG_CLK_PERIOD_NS)

`endif

// ---- verilog/cpg_divider.sv ----
`timescale 1ns/1ps
module cpg_divider
    import cpg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [4:0] divisor,
    output logic            tick
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic       next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (run) begin
            if (count + 5'h01 >= divisor) begin
                next_count = 5'h00;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count <= 5'h00;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : cpg_divider

// ---- verilog/cpg_pkg.sv ----
package cpg_pkg;
    typedef enum logic [1:0] {
        CPG_RUN,
        CPG_STOPPED,
        CPG_SETTLE
    } cpg_state_e;
    typedef logic [2:0] cpg_ratio_t;
endpackage : cpg_pkg
